// ---- inc/charger_topoff_pkg.sv ----
// constants of the top-off configuration register block
package charger_topoff_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] CFG3_OFFSET      = 8'h19;
   localparam logic [7:0] CFG3_RESET       = 8'h80;
   localparam logic [7:0] UNMAPPED_DATA    = 8'h00;
   localparam int         TRACK_OFF_BIT    = 7;
   localparam int         OCP_SEL_BIT      = 6;
   localparam int         TOPOFF_DURATION_SEL_MSB      = 5;
   localparam int         TOPOFF_DURATION_SEL_LSB      = 3;
   localparam int         TOPOFF_CURRENT_THRESHOLD_MSB       = 2;
   localparam int         TOPOFF_CURRENT_THRESHOLD_LSB       = 0;
   // ==========================================================
   // status codes
   localparam logic [3:0] DETAILS_OTHER    = 4'h0;
   localparam logic [3:0] DETAILS_TOPOFF   = 4'h4;
   localparam logic [3:0] DETAILS_DONE     = 4'h5;
   // ==========================================================
   // thresholds in mA per code
   localparam logic [11:0] ITH_MA [8] = '{12'h019, 12'h032, 12'h064,
      12'h0C8, 12'h190, 12'h258, 12'h3E8, 12'h640};
   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned OCP_SHORT_MS = 6;
   localparam int unsigned OCP_LONG_MS  = 100;
   localparam int unsigned TO_SHORT_MS  = 100;
   localparam int unsigned TO_MID_SEC   = 30;
   localparam int unsigned TO_STEP_MIN  = 10;
   localparam int unsigned TRACK_DIV    = 25;
   localparam int unsigned OCP_SHORT_CYC = CLK_HZ / 1000 * OCP_SHORT_MS;
   localparam int unsigned OCP_LONG_CYC  = CLK_HZ / 1000 * OCP_LONG_MS;
   localparam int unsigned TO_SHORT_CYC  = CLK_HZ / 1000 * TO_SHORT_MS;
   localparam int unsigned TO_MID_CYC    = CLK_HZ * TO_MID_SEC;
   localparam int unsigned TO_MIN_CYC    = CLK_HZ * 60;
   localparam logic [2:0]  TO_CODE_SHORT = 3'h0;
   localparam logic [2:0]  TO_CODE_MID   = 3'h1;
endpackage : charger_topoff_pkg

// ---- hw/charger_topoff_config_reg.sv ----
// top-off configuration register and its charge-state logic
`timescale 1ns/1ns

// Operation
// - With the tracking bit clear, the system target is the larger of battery plus 4% and the minimum system voltage.
// - With the tracking bit set, the system target is the charge termination voltage.
// - Bit 6 selects a 6 ms or 100 ms overcurrent debounce and resets to 0.
// - An overcurrent lasting the debounce interval turns the converter off.
// - Bits 5:3 select top-off time 100 ms, 30 s, or 10 to 60 minutes.
// - Bits 2:0 select a top-off threshold of 25 to 1600 mA.
// - In constant-voltage charge, current at or below the threshold enters top-off.
// - Entering top-off pulses the charger event interrupt.
// - During top-off the details status shows the top-off code.
// - Entering top-off starts the top-off timer for the selected time.
// - Reading the threshold returns the value the charger uses.
module charger_topoff_config_reg #(
   parameter int unsigned OCP_SHORT_CYC = charger_topoff_pkg::OCP_SHORT_CYC,
   parameter int unsigned OCP_LONG_CYC  = charger_topoff_pkg::OCP_LONG_CYC,
   parameter int unsigned TO_SHORT_CYC  = charger_topoff_pkg::TO_SHORT_CYC,
   parameter int unsigned TO_MID_CYC    = charger_topoff_pkg::TO_MID_CYC,
   parameter int unsigned TO_MIN_CYC    = charger_topoff_pkg::TO_MIN_CYC
) (
   // clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST_N,
   // register port
   input  wire logic [7:0]  I_ADDR,
   input  wire logic        I_WR_EN,
   input  wire logic [7:0]  I_WR_DATA,
   input  wire logic        I_RD_EN,
   output logic      [7:0]  O_RD_DATA,
   // charger measurements
   input  wire logic        I_CHARGE_EN,
   input  wire logic        I_CV_STATE,
   input  wire logic [11:0] I_CHARGE_CURRENT_MA,
   input  wire logic [15:0] I_BATT_MV,
   input  wire logic [15:0] I_SYSTEM_MIN_VOLTAGE_MV,
   input  wire logic [15:0] I_CHARGE_TERMINATION_VOLTAGE_MV,
   input  wire logic        I_OVERCURRENT_CONDITION,
   // results
   output logic [15:0]      O_SYS_TARGET_MV,
   output logic             O_CONVERTER_OFF,
   output logic             O_CHARGER_EVENT_IRQ,
   output logic [3:0]       O_CHARGER_DETAILS_STATUS
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_TOPOFF = 3'h2,
      ST_DONE   = 3'h4
   } chg_state_t;

   typedef struct packed {
      logic [7:0]  cfg;
      chg_state_t  state;
      logic [35:0] timer;
      logic [19:0] oc_cnt;
      logic        oc_s1;
      logic        oc_s2;
      logic        oc_s3;
      logic        oc_f;
      logic        conv_off;
      logic        irq;
      logic [3:0]  details;
      logic [7:0]  rd_data;
      logic [15:0] sys_target;
   } regs_t;

   regs_t s_r;
   regs_t s_nxt;

   // ==========================================================
   // helpers
   function automatic logic [35:0] topoff_limit(input logic [2:0] code);
      logic [39:0] v;
      v = 40'(code - 3'h1) * 40'(charger_topoff_pkg::TO_STEP_MIN)
          * 40'(TO_MIN_CYC);
      if (code == charger_topoff_pkg::TO_CODE_SHORT) begin
         v = 40'(TO_SHORT_CYC);
      end else if (code == charger_topoff_pkg::TO_CODE_MID) begin
         v = 40'(TO_MID_CYC);
      end
      return v[35:0];
   endfunction : topoff_limit

   logic [2:0]  ith_code;
   logic [2:0]  time_code;
   logic [11:0] ith_ma;
   logic [35:0] to_limit;
   logic [19:0] oc_limit;
   logic [16:0] batt_plus;
   logic        topoff_entry;
   logic        topoff_expire;

   assign ith_code  = s_r.cfg[charger_topoff_pkg::TOPOFF_CURRENT_THRESHOLD_MSB:
                              charger_topoff_pkg::TOPOFF_CURRENT_THRESHOLD_LSB];
   assign time_code = s_r.cfg[charger_topoff_pkg::TOPOFF_DURATION_SEL_MSB:
                              charger_topoff_pkg::TOPOFF_DURATION_SEL_LSB];
   assign ith_ma    = charger_topoff_pkg::ITH_MA[ith_code];
   assign to_limit  = topoff_limit(time_code);
   assign oc_limit  = s_r.cfg[charger_topoff_pkg::OCP_SEL_BIT] ?
                      20'(OCP_LONG_CYC) : 20'(OCP_SHORT_CYC);
   assign batt_plus = {1'b0, I_BATT_MV} + 17'(I_BATT_MV /
                      16'(charger_topoff_pkg::TRACK_DIV));
   assign topoff_entry  = I_CHARGE_EN && I_CV_STATE &&
                          (I_CHARGE_CURRENT_MA <= ith_ma);
   assign topoff_expire = (s_r.timer >= to_limit - 36'h1);

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.irq = 1'b0;
      // register port
      if (I_WR_EN && (I_ADDR == charger_topoff_pkg::CFG3_OFFSET)) begin
         s_nxt.cfg = I_WR_DATA;
      end
      if (I_RD_EN) begin
         s_nxt.rd_data = (I_ADDR == charger_topoff_pkg::CFG3_OFFSET) ?
                         s_r.cfg : charger_topoff_pkg::UNMAPPED_DATA;
      end
      // system rail target
      if (s_r.cfg[charger_topoff_pkg::TRACK_OFF_BIT]) begin
         s_nxt.sys_target = I_CHARGE_TERMINATION_VOLTAGE_MV;
      end else if (batt_plus[15:0] > I_SYSTEM_MIN_VOLTAGE_MV) begin
         s_nxt.sys_target = batt_plus[15:0];
      end else begin
         s_nxt.sys_target = I_SYSTEM_MIN_VOLTAGE_MV;
      end
      // overcurrent filter and debounce
      s_nxt.oc_s1 = I_OVERCURRENT_CONDITION;
      s_nxt.oc_s2 = s_r.oc_s1;
      s_nxt.oc_s3 = s_r.oc_s2;
      if (s_r.oc_s2 == s_r.oc_s3) begin
         s_nxt.oc_f = s_r.oc_s3;
      end
      if (!s_r.oc_f) begin
         s_nxt.oc_cnt   = 20'h00000;
         s_nxt.conv_off = 1'b0;
      end else if (s_r.oc_cnt >= oc_limit - 20'h00001) begin
         s_nxt.conv_off = 1'b1;
      end else begin
         s_nxt.oc_cnt = s_r.oc_cnt + 20'h00001;
      end
      // charge state
      unique case (s_r.state)
         ST_IDLE: begin
            s_nxt.timer = 36'h0;
            if (topoff_entry) begin
               s_nxt.state   = ST_TOPOFF;
               s_nxt.irq     = 1'b1;
               s_nxt.details = charger_topoff_pkg::DETAILS_TOPOFF;
            end
         end
         ST_TOPOFF: begin
            s_nxt.timer = s_r.timer + 36'h1;
            if (!I_CHARGE_EN) begin
               s_nxt.state   = ST_IDLE;
               s_nxt.details = charger_topoff_pkg::DETAILS_OTHER;
            end else if (topoff_expire) begin
               s_nxt.state   = ST_DONE;
               s_nxt.details = charger_topoff_pkg::DETAILS_DONE;
            end
         end
         ST_DONE: begin
            s_nxt.timer = 36'h0;
            if (!I_CHARGE_EN) begin
               s_nxt.state   = ST_IDLE;
               s_nxt.details = charger_topoff_pkg::DETAILS_OTHER;
            end
         end
         default: begin
            s_nxt.state   = ST_IDLE;
            s_nxt.details = charger_topoff_pkg::DETAILS_OTHER;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s_r <= '{cfg: charger_topoff_pkg::CFG3_RESET, state: ST_IDLE,
                  timer: 36'h0, oc_cnt: 20'h00000, oc_s1: 1'b0,
                  oc_s2: 1'b0, oc_s3: 1'b0, oc_f: 1'b0,
                  conv_off: 1'b0, irq: 1'b0,
                  details: charger_topoff_pkg::DETAILS_OTHER,
                  rd_data: 8'h00, sys_target: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign O_RD_DATA                = s_r.rd_data;
   assign O_SYS_TARGET_MV          = s_r.sys_target;
   assign O_CONVERTER_OFF          = s_r.conv_off;
   assign O_CHARGER_EVENT_IRQ      = s_r.irq;
   assign O_CHARGER_DETAILS_STATUS = s_r.details;

   // ==========================================================
   // checks
   a_track_off_target: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      s_r.cfg[charger_topoff_pkg::TRACK_OFF_BIT] |=>
      O_SYS_TARGET_MV == $past(I_CHARGE_TERMINATION_VOLTAGE_MV))
      else $error("target not termination voltage");

   a_track_on_target: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      !s_r.cfg[charger_topoff_pkg::TRACK_OFF_BIT] |=>
      O_SYS_TARGET_MV >= $past(I_SYSTEM_MIN_VOLTAGE_MV) &&
      O_SYS_TARGET_MV >= $past(batt_plus[15:0]))
      else $error("tracking target too low");

   a_debounce_count: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (s_r.oc_f && s_r.oc_cnt < oc_limit - 20'h00001) |=>
      s_r.oc_cnt == $past(s_r.oc_cnt) + 20'h00001)
      else $error("debounce count not advancing");

   a_overcurrent_trip: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(O_CONVERTER_OFF) |->
      $past(s_r.oc_f) && $past(s_r.oc_cnt) == oc_limit - 20'h00001)
      else $error("converter off without full debounce");

   a_entry_irq: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (s_r.state == ST_IDLE && topoff_entry) |=>
      O_CHARGER_EVENT_IRQ && s_r.state == ST_TOPOFF ##1
      !O_CHARGER_EVENT_IRQ)
      else $error("top-off entry without one interrupt pulse");

   a_irq_cause: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      O_CHARGER_EVENT_IRQ |-> $past(s_r.state) == ST_IDLE &&
      $past(I_CHARGE_CURRENT_MA) <= $past(ith_ma) && $past(I_CV_STATE))
      else $error("interrupt without threshold crossing");

   a_topoff_status: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (s_r.state == ST_TOPOFF) ==
      (O_CHARGER_DETAILS_STATUS == charger_topoff_pkg::DETAILS_TOPOFF))
      else $error("status disagrees with top-off state");

   a_timer_start: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(s_r.state == ST_TOPOFF) |-> s_r.timer == 36'h0 ##1
      s_r.timer == 36'h1 || s_r.state != ST_TOPOFF)
      else $error("top-off timer not started from zero");

   a_timer_expiry: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (s_r.state == ST_TOPOFF && I_CHARGE_EN && topoff_expire) |=>
      s_r.state == ST_DONE &&
      O_CHARGER_DETAILS_STATUS == charger_topoff_pkg::DETAILS_DONE)
      else $error("no charge done after top-off time");

   a_threshold_read: assert property (
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_RD_EN && I_ADDR == charger_topoff_pkg::CFG3_OFFSET) |=>
      O_RD_DATA[charger_topoff_pkg::TOPOFF_CURRENT_THRESHOLD_MSB:
                charger_topoff_pkg::TOPOFF_CURRENT_THRESHOLD_LSB] == $past(ith_code))
      else $error("read threshold differs from used one");
endmodule : charger_topoff_config_reg

// ---- tb/charger_host_model.sv ----
// host model driving the register port of the charger block
`timescale 1ns/1ns
module charger_host_model (
   // clock and read data
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rd_data,
   // register port
   output logic      [7:0] o_addr,
   output logic            o_wr_en,
   output logic      [7:0] o_wr_data,
   output logic            o_rd_en
);
   initial begin
      o_addr = 8'h00;
      o_wr_en = 1'b0;
      o_wr_data = 8'h00;
      o_rd_en = 1'b0;
   end
   // ==========================================================
   // one write, strobe held across one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(negedge i_clock);
      o_wr_en = 1'b0;
      o_wr_data = ~d;
   endtask : wr
   // one read, data taken two edges later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clock);
      o_addr = a;
      o_rd_en = 1'b1;
      @(negedge i_clock);
      o_rd_en = 1'b0;
      o_addr = ~a;
      @(negedge i_clock);
      d = i_rd_data;
   endtask : rd
endmodule : charger_host_model

// ---- tb/charger_topoff_config_reg_tb.sv ----
// self-checking bench of the top-off configuration register
`timescale 1ns/1ns
module charger_topoff_config_reg_tb;
   logic clk = 1'b0, rst_n = 1'b0, chg_en = 1'b0, cv = 1'b0, oc = 1'b0;
   logic [11:0] cur = 12'h000;
   logic [15:0] batt = 16'h0000, smin = 16'h0000, term = 16'h0000;
   logic [15:0] tgt, ex;
   logic [7:0]  addr, wdat, rdat, d, rb;
   logic        wen, ren, coff, irq;
   logic [3:0]  dtl;
   int num_errors = 0, check_count = 0, seed = 29, cyc = 0, n, lim;
   initial begin
      forever #50 clk = ~clk;
   end
   charger_host_model host (.i_clock(clk), .i_rd_data(rdat),
      .o_addr(addr), .o_wr_en(wen), .o_wr_data(wdat), .o_rd_en(ren));
   charger_topoff_config_reg #(.OCP_SHORT_CYC(20), .OCP_LONG_CYC(40),
      .TO_SHORT_CYC(30), .TO_MID_CYC(50), .TO_MIN_CYC(10)) dut (
      .I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WR_EN(wen),
      .I_WR_DATA(wdat), .I_RD_EN(ren), .O_RD_DATA(rdat),
      .I_CHARGE_EN(chg_en), .I_CV_STATE(cv), .I_CHARGE_CURRENT_MA(cur),
      .I_BATT_MV(batt), .I_SYSTEM_MIN_VOLTAGE_MV(smin),
      .I_CHARGE_TERMINATION_VOLTAGE_MV(term),
      .I_OVERCURRENT_CONDITION(oc), .O_SYS_TARGET_MV(tgt),
      .O_CONVERTER_OFF(coff), .O_CHARGER_EVENT_IRQ(irq),
      .O_CHARGER_DETAILS_STATUS(dtl));
   // ==========================================================
   // checking and closing
   task automatic chk(input string s, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task automatic tk(input int k);
      repeat (k) @(negedge clk);
   endtask : tk
   function automatic logic [11:0] thr(input int c);
      logic [11:0] t[8] = '{25, 50, 100, 200, 400, 600, 1000, 1600};
      return t[c];
   endfunction : thr
   function automatic int tlim(input int c);
      return (c == 0) ? 30 : (c == 1) ? 50 : (c - 1) * 100;
   endfunction : tlim
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         test_done();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      tk(20);
      rst_n = 1'b1;
      host.rd(8'h19, d);
      chk("reset_value", 16'h0080, {8'h00, d});
      host.rd(8'h33, d);
      chk("unmapped_read", 16'h0000, {8'h00, d});
      for (int i = 0; i < 8; i++) begin
         batt = 16'd6000 + ($random(seed) & 16'h1FFF);
         smin = 16'd6000 + ($random(seed) & 16'h1FFF);
         term = $random(seed);
         d = {i[0], 7'($random(seed))};
         host.wr(8'h19, d);
         host.wr(8'h1A, ~d);
         host.rd(8'h19, rb);
         chk("readback", {8'h00, d}, {8'h00, rb});
         ex = batt + batt / 25;
         if (smin > ex) ex = smin;
         if (d[7]) ex = term;
         chk("sys_target", ex, tgt);
      end
      for (int s = 0; s < 2; s++) begin
         host.wr(8'h19, {1'b0, s[0], 6'h00});
         oc = 1'b1;
         n = 0;
         while (coff !== 1'b1 && n < 200) begin
            tk(1);
            n++;
         end
         lim = s ? 40 : 20;
         chk("ocp_delay_ok", 1, n >= lim && n <= lim + 6);
         oc = 1'b0;
         tk(8);
         chk("converter_off", 0, coff);
      end
      for (int c = 0; c < 8; c++) begin
         chg_en = 1'b0;
         host.wr(8'h19, {2'b00, c[2:0], c[2:0]});
         chk("idle_details", 16'h0000, dtl);
         cur = thr(c);
         cv = 1'b0;
         chg_en = 1'b1;
         tk(4);
         chk("no_entry_cv", 16'h0000, {irq, dtl});
         cur = thr(c) + 12'h001;
         cv = 1'b1;
         tk(4);
         chk("no_entry", 16'h0000, {irq, dtl});
         cur = thr(c);
         n = 0;
         while (irq !== 1'b1 && n < 4) begin
            tk(1);
            n++;
         end
         chk("irq_pulse", 1, irq);
         tk(1);
         chk("irq_end", 0, irq);
         chk("topoff_details", 16'h0004, dtl);
         n = 1;
         while (dtl !== 4'h5 && n < tlim(c) + 10) begin
            tk(1);
            n++;
         end
         chk("timer_ok", 1, n >= tlim(c) - 2 && n <= tlim(c) + 3);
         chk("done_details", 16'h0005, dtl);
      end
      rst_n = 1'b0;
      tk(2);
      chk("reset_outputs", 16'h0000, {coff, irq, dtl, rdat});
      rst_n = 1'b1;
      host.rd(8'h19, d);
      chk("reset_again", 16'h0080, {8'h00, d});
      test_done();
   end
endmodule : charger_topoff_config_reg_tb
